// file: verilog/gpio_pkg.sv
package gpio_pkg;
    // pin bitmap: bits 0..15, 17 and 18 are real pins
    localparam int unsigned MAP_W = 32;
    localparam logic [31:0] PIN_MASK = 32'h0006_FFFF;
    localparam int unsigned NUM_DO = 2;

    // register byte offsets
    localparam logic [7:0] OFF_INPUT_MASK = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_MASK = 8'h04;
    localparam logic [7:0] OFF_HIGH_MASK = 8'h08;
    localparam logic [7:0] OFF_LOW_MASK = 8'h0C;
    localparam logic [7:0] OFF_PULL_ON = 8'h10;
    localparam logic [7:0] OFF_PULL_OFF = 8'h14;
    localparam logic [7:0] OFF_APPLY = 8'h18;
    localparam logic [7:0] OFF_PIN_INPUT = 8'h1C;
    localparam logic [7:0] OFF_DIRECTION = 8'h20;
    localparam logic [7:0] OFF_LEVEL = 8'h24;
    localparam logic [7:0] OFF_PULL_STATE = 8'h28;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h2C;
    localparam logic [7:0] OFF_WAKE_ENABLE = 8'h30;
    localparam logic [7:0] OFF_EVENT = 8'h34;
    localparam logic [7:0] OFF_DO_LEVEL = 8'h38;

    // fields of the apply register
    localparam int unsigned APPLY_DIR_BIT = 0;
    localparam int unsigned APPLY_LEVEL_BIT = 1;
    localparam int unsigned APPLY_PULL_BIT = 2;

    // reset values
    localparam logic [31:0] DIR_RESET = 32'h0000_0000;
    localparam logic [31:0] LEVEL_RESET = 32'h0000_0000;
    localparam logic [31:0] PULL_RESET = PIN_MASK;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [NUM_DO-1:0] DO_RESET = '0;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // pin drive toward the pads
    typedef struct packed {
        logic [31:0] out;
        logic [31:0] oe;
    } pin_drive_t;

    // claim and drive from the shared peripherals
    typedef struct packed {
        logic [31:0] claim;
        logic [31:0] out;
        logic [31:0] oe;
    } periph_drive_t;

    // captured write command
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_cmd_t;
endpackage

// file: verilog/pin_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous pad levels
module pin_sync #(
    parameter int unsigned WIDTH = 32
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    // async in, synced out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_q <= '0;
            q <= '0;
        end else if (clk_en) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // pin_sync

// file: verilog/gpio_port.sv
// Functional notes
// - pins 0-15, 17, 18 sit on same bitmap bits; 16, 19-31 unused.
// - two extra output-only pins are provided.
// - after reset every bidirectional pin is an input.
// - direction update uses input mask and output mask.
// - pins clear in both masks keep their previous setting.
// - a pin set in both direction masks becomes an input.
// - direction on a claimed pin is stored, applied once released.
// - direction update never touches pull enables.
// - level update uses high mask and low mask.
// - a pin set in both level masks goes low.
// - level on an input pin is held, driven once made output.
// - level on a claimed pin waits until the peripheral releases it.
// - an enabled peripheral owns its pin outright.
// - input pins can raise interrupts and wake the device.
// - pin input read returns every pin level; unused bits zero.
// - all pull resistors enabled after power-up.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module gpio_port
    import gpio_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // bidirectional pins
    input wire logic [31:0] bidir_pin_in,
    output pin_drive_t bidir_pin,
    output logic [31:0] pull_enable,
    // output-only pins
    output logic [NUM_DO-1:0] do_pin_out,
    // shared peripherals
    input wire periph_drive_t periph,
    // pin events
    output logic pin_irq,
    output logic wake_req
);
    // refuse address widths that cannot reach the map
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
        $error("gpio_port: ADDR_W must be 6..32");
    end

    // staging masks and stored pin state
    logic [31:0] input_mask_q;
    logic [31:0] output_mask_q;
    logic [31:0] high_mask_q;
    logic [31:0] low_mask_q;
    logic [31:0] pull_on_q;
    logic [31:0] pull_off_q;
    logic [31:0] dir_q;
    logic [31:0] level_q;
    logic [31:0] pull_q;
    logic [31:0] int_en_q;
    logic [31:0] wake_en_q;
    logic [31:0] event_q;
    logic [NUM_DO-1:0] do_q;
    // bus slave state
    logic aw_full_q;
    logic w_full_q;
    wr_cmd_t wr_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    // pin input path
    logic [31:0] pin_sync;
    logic [31:0] pin_prev_q;
    logic [31:0] change;
    logic wake_q;
    // decoded write
    logic wr_fire;
    logic wr_hit;
    logic [31:0] wr_mask;
    logic [31:0] wr_merged;
    logic apply_dir;
    logic apply_level;
    logic apply_pull;
    logic [31:0] rd_word;
    logic rd_hit;

    // synchronise the pad levels before any logic reads them
    pin_sync #(
        .WIDTH(MAP_W)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .d(bidir_pin_in),
        .q(pin_sync)
    );

    // channels refuse new items while a response is pending or held
    assign s_axi_awready = clk_en && !aw_full_q && !bvalid_q;
    assign s_axi_wready = clk_en && !w_full_q && !bvalid_q;
    assign s_axi_arready = clk_en && !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // address and data may arrive in either order
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            wr_q <= '0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                wr_q.addr <= {2'b00, s_axi_awaddr[5:0]};
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wr_q.data <= s_axi_wdata;
                wr_q.strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // the write acts one cycle after both halves are held
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

    // byte strobes become a bit mask for partial writes
    always_comb begin
        wr_mask = {{8{wr_q.strb[3]}}, {8{wr_q.strb[2]}},
                   {8{wr_q.strb[1]}}, {8{wr_q.strb[0]}}};
    end

    // write decode; read-only and unknown offsets answer slverr
    always_comb begin
        wr_hit = 1'b1;
        case (wr_q.addr)
            OFF_INPUT_MASK, OFF_OUTPUT_MASK, OFF_HIGH_MASK, OFF_LOW_MASK,
            OFF_PULL_ON, OFF_PULL_OFF, OFF_APPLY, OFF_INT_ENABLE,
            OFF_WAKE_ENABLE, OFF_EVENT, OFF_DO_LEVEL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // apply strobes; the strobe of byte 0 gates the command
    assign apply_dir = wr_fire && wr_q.addr == OFF_APPLY &&
        wr_q.strb[0] && wr_q.data[APPLY_DIR_BIT];
    assign apply_level = wr_fire && wr_q.addr == OFF_APPLY &&
        wr_q.strb[0] && wr_q.data[APPLY_LEVEL_BIT];
    assign apply_pull = wr_fire && wr_q.addr == OFF_APPLY &&
        wr_q.strb[0] && wr_q.data[APPLY_PULL_BIT];

    // write response, held until the master takes it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // merged value for plain storage registers; unused bits stay zero
    assign wr_merged = wr_q.data & wr_mask & PIN_MASK;

    // staging masks: only stored here, acted on by the apply register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            input_mask_q <= ZERO_WORD;
            output_mask_q <= ZERO_WORD;
            high_mask_q <= ZERO_WORD;
            low_mask_q <= ZERO_WORD;
            pull_on_q <= ZERO_WORD;
            pull_off_q <= ZERO_WORD;
        end else if (clk_en && wr_fire) begin
            case (wr_q.addr)
                OFF_INPUT_MASK:
                    input_mask_q <= (input_mask_q & ~wr_mask) | wr_merged;
                OFF_OUTPUT_MASK:
                    output_mask_q <= (output_mask_q & ~wr_mask) | wr_merged;
                OFF_HIGH_MASK:
                    high_mask_q <= (high_mask_q & ~wr_mask) | wr_merged;
                OFF_LOW_MASK:
                    low_mask_q <= (low_mask_q & ~wr_mask) | wr_merged;
                OFF_PULL_ON:
                    pull_on_q <= (pull_on_q & ~wr_mask) | wr_merged;
                OFF_PULL_OFF:
                    pull_off_q <= (pull_off_q & ~wr_mask) | wr_merged;
                default: begin
                end
            endcase
        end
    end

    // direction: all bits in one edge, input wins, untouched bits hold
    // pull state is not in this process at all
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dir_q <= DIR_RESET;
        end else if (clk_en && apply_dir) begin
            dir_q <= ((dir_q & ~(input_mask_q | output_mask_q))
                | (output_mask_q & ~input_mask_q))
                & PIN_MASK;
        end
    end

    // output level: stored even for inputs or claimed pins; low wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            level_q <= LEVEL_RESET;
        end else if (clk_en && apply_level) begin
            level_q <= ((level_q & ~(high_mask_q | low_mask_q))
                | (high_mask_q & ~low_mask_q))
                & PIN_MASK;
        end
    end

    // pull enables have their own control; off wins over on
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pull_q <= PULL_RESET;
        end else if (clk_en && apply_pull) begin
            pull_q <= ((pull_q & ~(pull_on_q | pull_off_q))
                | (pull_on_q & ~pull_off_q)) & PIN_MASK;
        end
    end
    assign pull_enable = pull_q;

    // event enables and the output-only pin levels
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            int_en_q <= ZERO_WORD;
            wake_en_q <= ZERO_WORD;
            do_q <= DO_RESET;
        end else if (clk_en && wr_fire) begin
            case (wr_q.addr)
                OFF_INT_ENABLE:
                    int_en_q <= (int_en_q & ~wr_mask) | wr_merged;
                OFF_WAKE_ENABLE:
                    wake_en_q <= (wake_en_q & ~wr_mask) | wr_merged;
                OFF_DO_LEVEL: begin
                    if (wr_q.strb[0]) begin
                        do_q <= wr_q.data[NUM_DO-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end
    assign do_pin_out = do_q;

    // pad drive per pin: an enabled peripheral owns the pin, otherwise
    // the stored level is driven only while the pin is an output;
    // unused bitmap positions never drive
    for (genvar i = 0; i < MAP_W; i++) begin : g_pin
        always_comb begin
            if (!PIN_MASK[i]) begin
                bidir_pin.out[i] = 1'b0;
                bidir_pin.oe[i] = 1'b0;
            end else if (periph.claim[i]) begin
                bidir_pin.out[i] = periph.out[i];
                bidir_pin.oe[i] = periph.oe[i];
            end else begin
                bidir_pin.out[i] = level_q[i];
                bidir_pin.oe[i] = dir_q[i];
            end
        end
    end

    // any edge on an input-configured, unclaimed pin is an event
    assign change = (pin_sync ^ pin_prev_q) & ~dir_q & ~periph.claim
        & PIN_MASK;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_prev_q <= ZERO_WORD;
        end else if (clk_en) begin
            pin_prev_q <= pin_sync;
        end
    end

    // sticky events, write-one-to-clear; a new edge beats the clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            event_q <= ZERO_WORD;
        end else if (clk_en) begin
            if (wr_fire && wr_q.addr == OFF_EVENT) begin
                event_q <= (event_q & ~wr_merged) | (change & int_en_q);
            end else begin
                event_q <= event_q | (change & int_en_q);
            end
        end
    end
    assign pin_irq = |event_q;

    // wake request is a one-cycle pulse per qualifying edge
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else if (clk_en) begin
            wake_q <= |(change & wake_en_q);
        end
    end
    assign wake_req = wake_q;

    // read mux; pin input shows every real pin whoever drives it
    always_comb begin
        rd_hit = 1'b1;
        rd_word = ZERO_WORD;
        case ({2'b00, s_axi_araddr[5:0]})
            OFF_INPUT_MASK: rd_word = input_mask_q;
            OFF_OUTPUT_MASK: rd_word = output_mask_q;
            OFF_HIGH_MASK: rd_word = high_mask_q;
            OFF_LOW_MASK: rd_word = low_mask_q;
            OFF_PULL_ON: rd_word = pull_on_q;
            OFF_PULL_OFF: rd_word = pull_off_q;
            OFF_APPLY: rd_word = ZERO_WORD;
            OFF_PIN_INPUT: rd_word = pin_sync & PIN_MASK;
            OFF_DIRECTION: rd_word = dir_q;
            OFF_LEVEL: rd_word = level_q;
            OFF_PULL_STATE: rd_word = pull_q;
            OFF_INT_ENABLE: rd_word = int_en_q;
            OFF_WAKE_ENABLE: rd_word = wake_en_q;
            OFF_EVENT: rd_word = event_q;
            OFF_DO_LEVEL: rd_word = {{(32-NUM_DO){1'b0}}, do_q};
            default: rd_hit = 1'b0;
        endcase
        if (s_axi_araddr[1:0] != 2'b00) begin
            rd_hit = 1'b0;
            rd_word = ZERO_WORD;
        end
    end

    // read answer registered one cycle after the address is taken
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= ZERO_WORD;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_q <= rd_word;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end
endmodule // gpio_port

// file: tb/gpio_port_props.sv
`timescale 1ns/1ps
// concurrent checks on the pin port, watching its ports only
module gpio_port_props
    import gpio_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // bus signals that mark accesses
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    // pin side
    input wire pin_drive_t bidir_pin,
    input wire logic [31:0] pull_enable,
    input wire periph_drive_t periph,
    input wire logic wake_req
);
    logic rd_pin_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // remember whether the read in flight targets the pin input word
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_pin_q <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_pin_q <= (s_axi_araddr[5:0] == OFF_PIN_INPUT[5:0]);
        end
    end

    unused_idle_a:
        assert property (((bidir_pin.oe | bidir_pin.out) & ~PIN_MASK) == 0)
        else $error("unused pin position driven");
    reset_input_a:
        assert property ($fell(reset) |-> (bidir_pin.oe & ~periph.claim) == 0)
        else $error("unclaimed pin driven after reset");
    pull_power_a:
        assert property ($fell(reset) |-> pull_enable == PULL_RESET)
        else $error("pull enables wrong after reset");
    claim_dir_a:
        assert property (((bidir_pin.oe ^ periph.oe) & periph.claim) == 0)
        else $error("claimed pin enable not from peripheral");
    claim_level_a:
        assert property (((bidir_pin.out ^ periph.out) & periph.claim) == 0)
        else $error("claimed pin level not from peripheral");
    dir_hold_a:
        assert property (!$stable(bidir_pin.oe) |-> $rose(s_axi_bvalid)
            || !$stable(periph.claim) || !$stable(periph.oe))
        else $error("pin enable moved without a cause");
    level_hold_a:
        assert property (!$stable(bidir_pin.out) |-> $rose(s_axi_bvalid)
            || !$stable(periph.claim) || !$stable(periph.out))
        else $error("pin level moved without a cause");
    pull_hold_a:
        assert property (!$stable(pull_enable) |-> $rose(s_axi_bvalid))
        else $error("pull enables moved without a write");
    wake_pulse_a:
        assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    read_unused_a:
        assert property (s_axi_rvalid && rd_pin_q
            |-> (s_axi_rdata & ~PIN_MASK) == 0)
        else $error("unused pin bits read as one");
endmodule // gpio_port_props

bind gpio_port gpio_port_props #(.ADDR_W(ADDR_W)) props_u (
    .clk_sys(clk_sys),
    .reset(reset),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bvalid(s_axi_bvalid),
    .bidir_pin(bidir_pin),
    .pull_enable(pull_enable),
    .periph(periph),
    .wake_req(wake_req)
);

// file: tb/pin_far_model.sv
`timescale 1ns/1ps
// external circuitry on the pads: drivers, pull-ups, floating lines
module pin_far_model
    import gpio_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // port drive and pulls
    input wire pin_drive_t bidir_pin,
    input wire logic [31:0] pull_enable,
    // external drivers set by the bench
    input wire logic [31:0] ext_oe,
    input wire logic [31:0] ext_val,
    // resolved pad levels
    output logic [31:0] pad
);
    logic [31:0] float_q;

    // a floating pad flips each cycle so no stale level can pass as real
    initial float_q = 32'h5555_5555;
    always @(posedge clk_sys) float_q <= ~float_q;

    // port drive wins, then external driver, then pull-up, else floating
    assign pad = (bidir_pin.oe & bidir_pin.out)
        | (~bidir_pin.oe & ext_oe & ext_val)
        | (~bidir_pin.oe & ~ext_oe & pull_enable)
        | (~bidir_pin.oe & ~ext_oe & ~pull_enable & float_q);
endmodule // pin_far_model

// file: tb/test_gpio_port.sv
`timescale 1ns/1ps
module test_gpio_port
    import gpio_pkg::*;
;
    logic clk_sys, reset, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pin_irq, wake_req, woke;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, ext_oe, ext_val, pad, pull_enable;
    logic [1:0] bresp, rresp, do_pin_out;
    pin_drive_t bidir_pin;
    periph_drive_t periph;
    int n_fail = 0;
    int comparisons = 0;

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    gpio_port #(.ADDR_W(8)) dut_u (
        .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'b000),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bidir_pin_in(pad), .bidir_pin(bidir_pin),
        .pull_enable(pull_enable), .do_pin_out(do_pin_out),
        .periph(periph), .pin_irq(pin_irq), .wake_req(wake_req)
    );

    pin_far_model far_u (
        .clk_sys(clk_sys), .bidir_pin(bidir_pin), .pull_enable(pull_enable),
        .ext_oe(ext_oe), .ext_val(ext_val), .pad(pad)
    );

    // one comparison, counted and reported
    task automatic chk(input string nm, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // bus write: address and data together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask

    // bus read with expected data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, ed);
        chk("rresp", 32'(rresp), 32'(er));
    endtask

    // stage two masks, then apply the selected update
    task automatic upd(input logic [7:0] a, input logic [31:0] m0, m1,
                       input logic [31:0] ap);
        wr(a, m0, RESP_OKAY);
        wr(a + 8'h04, m1, RESP_OKAY);
        wr(OFF_APPLY, ap, RESP_OKAY);
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #(25 * 20000);
        n_fail++;
        summarize();
    end

    // test sequence
    initial begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        periph = '0;
        ext_oe = 32'h0000_00F4;
        ext_val = 32'h0000_0000;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        chk("oe", bidir_pin.oe, ZERO_WORD);
        rd(OFF_DIRECTION, DIR_RESET, RESP_OKAY);
        rd(OFF_PULL_STATE, PIN_MASK, RESP_OKAY);
        upd(OFF_INPUT_MASK, 32'h0000_0000, 32'hFFFF_FFFF, 1);
        chk("oe", bidir_pin.oe, PIN_MASK);
        upd(OFF_INPUT_MASK, 32'h0000_00F4, 32'h0000_0034, 1);
        chk("oe", bidir_pin.oe, 32'h0006_FF0B);
        rd(OFF_PULL_STATE, PIN_MASK, RESP_OKAY);
        upd(OFF_HIGH_MASK, 32'h0000_00FF, 32'h0000_0003, 2);
        rd(OFF_LEVEL, 32'h0000_00FC, RESP_OKAY);
        chk("pad", pad & 32'h0000_00F0, ZERO_WORD);
        rd(OFF_PIN_INPUT, 32'h0000_0008, RESP_OKAY);
        upd(OFF_HIGH_MASK, 32'h0000_0000, 32'h0000_00C0, 2);
        ext_oe <= 32'h0000_0004;
        upd(OFF_INPUT_MASK, 32'h0000_0000, 32'h0000_00F0, 1);
        chk("pad", pad & 32'h0000_00F0, 32'h0000_0030);
        // peripheral claims pins 8 and 9 and drives them low
        periph <= '{claim: 32'h0000_0300, out: '0, oe: 32'h0000_0300};
        upd(OFF_INPUT_MASK, 32'h0000_0100, 32'h0000_0000, 1);
        upd(OFF_HIGH_MASK, 32'h0000_0200, 32'h0000_0000, 2);
        chk("oe", bidir_pin.oe & 32'h0000_0300, 32'h0000_0300);
        chk("out", bidir_pin.out & 32'h0000_0300, ZERO_WORD);
        periph <= '0;
        @(posedge clk_sys);
        @(posedge clk_sys);
        chk("oe", bidir_pin.oe & 32'h0000_0300, 32'h0000_0200);
        chk("out", bidir_pin.out & 32'h0000_0300, 32'h0000_0200);
        upd(OFF_PULL_ON, 32'h0000_0000, 32'h0000_0001, 4);
        rd(OFF_PULL_STATE, 32'h0006_FFFE, RESP_OKAY);
        wr(8'h3C, 32'h0000_0001, RESP_SLVERR);
        wr(OFF_PIN_INPUT, 32'h0000_0001, RESP_SLVERR);
        rd(8'h3C, ZERO_WORD, RESP_SLVERR);
        rd(OFF_PIN_INPUT + 8'h01, ZERO_WORD, RESP_SLVERR);
        wr(OFF_DO_LEVEL, 32'h0000_0003, RESP_OKAY);
        chk("do", 32'(do_pin_out), 32'h0000_0003);
        // input pin 2 toggles with interrupt and wake enabled
        wr(OFF_INT_ENABLE, 32'h0000_0004, RESP_OKAY);
        wr(OFF_WAKE_ENABLE, 32'h0000_0004, RESP_OKAY);
        ext_val <= 32'h0000_0004;
        woke = 1'b0;
        for (int i = 0; i < 20 && !(pin_irq === 1'b1 && woke); i++) begin
            @(posedge clk_sys);
            if (wake_req === 1'b1) woke = 1'b1;
        end
        chk("irq", 32'(pin_irq), 32'h0000_0001);
        chk("wake", 32'(woke), 32'h0000_0001);
        rd(OFF_EVENT, 32'h0000_0004, RESP_OKAY);
        wr(OFF_EVENT, 32'h0000_0004, RESP_OKAY);
        @(posedge clk_sys);
        chk("irq", 32'(pin_irq), ZERO_WORD);
        summarize();
    end
endmodule // test_gpio_port
